// *** hdl/rx_port_cfg_regs.sv ***
// receive port register bank: interrupt pin routing, shared pin use,
// data clock loop controls and loop status
// assumes a serial port decoder in front giving single-cycle strobes
//
// Overview of operation
// - route bit set sends source to second pin
// - shared pin field: none, parity, frame, reserved
// - control bit 6 switches duty correction
// - phase offset signed magnitude, valid -6..+6
// - clear bit write clears status warnings
// - status reports near, start, end warnings
// - status bit 2 shows data clock present
// - status bit 0 shows loop tracking
// - loop warning latched, then routed to pin
`timescale 1ns/1ps
`default_nettype none

module rx_port_cfg_regs
	import rx_port_cfg_pkg::*;
(
	// clock, reset, enable
	input  wire logic            clk_i,
	input  wire logic            reset_i,
	input  wire logic            ce_i,
	// register access
	input  wire logic            wr_en_i,
	input  wire logic            rd_en_i,
	input  wire logic [7:0]      addr_i,
	input  wire logic [7:0]      wdata_i,
	output var  logic [7:0]      rdata_o,
	// interrupt sources and pins
	input  wire logic [7:0]      event_flag_i,
	input  wire logic            loop_warn_flag_clr_i,
	output var  logic            irq_pin_first_n_o,
	output var  logic            irq_pin_second_n_o,
	// loop side
	input  wire loop_status_type loop_status_i,
	output var  loop_ctrl_type   loop_ctrl_o,
	output var  logic [7:0]      status_o
);

	// -----------------------------------------------------------------
	// decoding
	// -----------------------------------------------------------------

	// write strobe for one register
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = wr_en_i && (addr_i == ofs);
	endfunction

	// signed magnitude phase offset to two's complement, zero if invalid
	function automatic logic [3:0] phase_twos(input logic [3:0] v);
		logic [3:0] mag;
		mag = {1'b0, v[2:0]};
		if (v[2:0] > PHASE_MAG_MAX)
			phase_twos = 4'h0;
		else if (v[3])
			phase_twos = 4'(-mag);
		else
			phase_twos = mag;
	endfunction

	logic [7:0] route_q;
	logic [7:0] pin_fn_q;
	logic [7:0] loop_ctrl_q;
	logic [7:0] warn_clr_q;
	logic [7:0] reserved_q;
	logic [7:0] rate_mode_q;
	logic [7:0] status_q;
	logic       loop_warn_latch_q;
	logic [7:0] src_flags;
	logic       clear_warn;
	logic [7:0] status_d;

	assign clear_warn = wr_hit(OFS_RX_WARNING_CLEAR_CTRL)
		&& wdata_i[POS_CLEAR_WARNINGS];

	// -----------------------------------------------------------------
	// writable registers
	// -----------------------------------------------------------------

	// host writes, reserved bits of the masked registers held at zero
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			route_q     <= RST_IRQ_PIN_ROUTE_B;
			pin_fn_q    <= RST_SHARED_PIN_FUNCTION;
			loop_ctrl_q <= RST_RX_CLOCK_LOOP_CTRL;
			warn_clr_q  <= RST_RX_WARNING_CLEAR_CTRL;
			reserved_q  <= RST_RX_RESERVED_CTRL;
			rate_mode_q <= RST_RX_CLOCK_RATE_MODE;
		end
		else if (ce_i)
		begin
			if (wr_hit(OFS_IRQ_PIN_ROUTE_B))
				route_q <= wdata_i & MSK_IRQ_PIN_ROUTE_B;
			if (wr_hit(OFS_SHARED_PIN_FUNCTION))
				pin_fn_q <= wdata_i & MSK_SHARED_PIN_FUNCTION;
			if (wr_hit(OFS_RX_CLOCK_LOOP_CTRL))
				loop_ctrl_q <= wdata_i & MSK_RX_CLOCK_LOOP_CTRL;
			if (wr_hit(OFS_RX_WARNING_CLEAR_CTRL))
				warn_clr_q <= wdata_i;
			if (wr_hit(OFS_RX_RESERVED_CTRL))
				reserved_q <= wdata_i;
			if (wr_hit(OFS_RX_CLOCK_RATE_MODE))
				rate_mode_q <= wdata_i & MSK_RX_CLOCK_RATE_MODE;
		end
	end

	// -----------------------------------------------------------------
	// loop status
	// -----------------------------------------------------------------

	// next status: lock and tracking only while loop enabled
	always_comb
	begin
		status_d = 8'h00;
		status_d[POS_STAT_LOCKED] = loop_ctrl_q[POS_LOOP_ENABLE]
			&& loop_status_i.locked;
		status_d[POS_STAT_WARN] = loop_status_i.near_warn
			|| (status_q[POS_STAT_WARN] && !clear_warn);
		status_d[POS_STAT_START_WARN] = loop_status_i.start_warn
			|| (status_q[POS_STAT_START_WARN] && !clear_warn);
		status_d[POS_STAT_END_WARN] = loop_status_i.end_warn
			|| (status_q[POS_STAT_END_WARN] && !clear_warn);
		status_d[POS_STAT_CLOCK_PRES] =
			loop_status_i.data_clock_present;
		status_d[POS_STAT_TRACKING] = loop_ctrl_q[POS_LOOP_ENABLE]
			&& loop_status_i.loop_tracking;
	end

	// status is never written by the host
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			status_q <= RST_RX_CLOCK_LOOP_STATUS;
		else if (ce_i)
			status_q <= status_d;
	end

	// -----------------------------------------------------------------
	// interrupt routing
	// -----------------------------------------------------------------

	// loop warning flag, a new warning beats the clear
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			loop_warn_latch_q <= 1'b0;
		else if (ce_i)
			loop_warn_latch_q <= loop_status_i.near_warn
				|| (loop_warn_latch_q && !loop_warn_flag_clr_i);
	end

	// sources in route register bit order, bit 3 unused
	always_comb
	begin
		src_flags = event_flag_i & MSK_IRQ_PIN_ROUTE_B;
		src_flags[POS_SRC_LOOP_WARNING] = loop_warn_latch_q;
	end

	// active low pins, route bit picks the second pin
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			irq_pin_first_n_o  <= 1'b1;
			irq_pin_second_n_o <= 1'b1;
		end
		else if (ce_i)
		begin
			irq_pin_first_n_o  <= ~|(src_flags & ~route_q);
			irq_pin_second_n_o <= ~|(src_flags & route_q);
		end
	end

	// -----------------------------------------------------------------
	// control outputs
	// -----------------------------------------------------------------

	// decoded fields toward the loop and the receiver
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			loop_ctrl_o <= '0;
		else if (ce_i)
		begin
			loop_ctrl_o.loop_enable <= loop_ctrl_q[POS_LOOP_ENABLE];
			loop_ctrl_o.duty_correction <=
				loop_ctrl_q[POS_DUTY_CORRECTION];
			loop_ctrl_o.phase_step <= phase_twos(loop_ctrl_q[3:0]);
			loop_ctrl_o.phase_valid <=
				loop_ctrl_q[2:0] <= PHASE_MAG_MAX;
			loop_ctrl_o.parity_select <=
				pin_function_type'(pin_fn_q[1:0]) == PIN_PARITY;
			loop_ctrl_o.frame_select <=
				pin_function_type'(pin_fn_q[1:0]) == PIN_FRAME;
			loop_ctrl_o.parity_in_use <= pin_fn_q[POS_PARITY_IN_USE];
			loop_ctrl_o.frame_in_use <= pin_fn_q[POS_FRAME_IN_USE];
			loop_ctrl_o.low_rate_clock_mode <=
				rate_mode_q[POS_LOW_RATE_MODE];
			loop_ctrl_o.delay_line_mode <= rate_mode_q[POS_DELAY_LINE_MODE];
		end
	end

	// status copy for the pins
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			status_o <= RST_RX_CLOCK_LOOP_STATUS;
		else if (ce_i)
			status_o <= status_d;
	end

	// -----------------------------------------------------------------
	// read back
	// -----------------------------------------------------------------

	// registered read data, unmapped offsets read zero
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			rdata_o <= 8'h00;
		else if (ce_i && rd_en_i)
		begin
			unique case (addr_i)
				OFS_IRQ_PIN_ROUTE_B:       rdata_o <= route_q;
				OFS_SHARED_PIN_FUNCTION:   rdata_o <= pin_fn_q;
				OFS_RX_CLOCK_LOOP_CTRL:    rdata_o <= loop_ctrl_q;
				OFS_RX_WARNING_CLEAR_CTRL: rdata_o <= warn_clr_q;
				OFS_RX_RESERVED_CTRL:      rdata_o <= reserved_q;
				OFS_RX_CLOCK_RATE_MODE:    rdata_o <= rate_mode_q;
				OFS_RX_CLOCK_LOOP_STATUS:  rdata_o <= status_q;
				default:                   rdata_o <= 8'h00;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------

	// host write that clears the warnings
	sequence clear_write_s;
		ce_i && clear_warn && !loop_status_i.near_warn
			&& !loop_status_i.start_warn && !loop_status_i.end_warn;
	endsequence

	// near warning bit standing with no clear write
	sequence warn_held_s;
		ce_i && status_q[POS_STAT_WARN] && !clear_warn;
	endsequence

	route_second_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i |=> irq_pin_second_n_o == !$past(|(src_flags & route_q)))
		else $error("second pin does not follow routed sources");

	route_first_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i && |(src_flags & ~route_q) |=> !irq_pin_first_n_o)
		else $error("first pin not asserted for its source");

	pin_function_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i |=> loop_ctrl_o.frame_select == ($past(pin_fn_q[1:0]) == 2'h2)
			&& loop_ctrl_o.parity_select == ($past(pin_fn_q[1:0]) == 2'h1))
		else $error("shared pin decode wrong");

	duty_write_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i && wr_en_i && addr_i == OFS_RX_CLOCK_LOOP_CTRL ##1 ce_i
			|=> loop_ctrl_o.duty_correction == $past(wdata_i[6], 2))
		else $error("duty correction does not follow write");

	phase_valid_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		loop_ctrl_o.phase_valid |-> loop_ctrl_o.phase_step != 4'h8
			&& (loop_ctrl_o.phase_step[3] ? loop_ctrl_o.phase_step >= 4'hA
			: loop_ctrl_o.phase_step <= 4'h6))
		else $error("phase step outside -6..+6");

	clear_warn_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		clear_write_s |=> status_q[6:4] == 3'h0)
		else $error("warning bits not cleared");

	warn_sticky_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		warn_held_s |=> status_q[POS_STAT_WARN])
		else $error("loop warning lost without clear");

	clock_present_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i |=> status_q[POS_STAT_CLOCK_PRES]
			== $past(loop_status_i.data_clock_present))
		else $error("clock present bit wrong");

	loop_tracking_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i && !loop_ctrl_q[POS_LOOP_ENABLE] |=> !status_q[0])
		else $error("tracking shown while loop disabled");

	warn_latch_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i && loop_status_i.near_warn |=> loop_warn_latch_q
			##0 (src_flags[POS_SRC_LOOP_WARNING]))
		else $error("loop warning flag not latched");

	lock_status_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i |=> status_q[7] == ($past(loop_ctrl_q[7])
			&& $past(loop_status_i.locked)))
		else $error("lock status wrong");

	status_ro_a: assert property (
		@(posedge clk_i) disable iff (reset_i)
		ce_i && wr_en_i && addr_i == OFS_RX_CLOCK_LOOP_STATUS
			|=> status_q == $past(status_d))
		else $error("status changed by host write");

endmodule

`default_nettype wire

// *** hdl/rx_port_cfg_pkg.sv ***
// package for the receive port configuration register bank
// shared by the register bank and anything that decodes its fields
package rx_port_cfg_pkg;

	// -----------------------------------------------------------------
	// register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] OFS_IRQ_PIN_ROUTE_B       = 8'h08;
	localparam logic [7:0] OFS_SHARED_PIN_FUNCTION   = 8'h09;
	localparam logic [7:0] OFS_RX_CLOCK_LOOP_CTRL    = 8'h0A;
	localparam logic [7:0] OFS_RX_WARNING_CLEAR_CTRL = 8'h0B;
	localparam logic [7:0] OFS_RX_RESERVED_CTRL      = 8'h0C;
	localparam logic [7:0] OFS_RX_CLOCK_RATE_MODE    = 8'h0D;
	localparam logic [7:0] OFS_RX_CLOCK_LOOP_STATUS  = 8'h0E;

	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] RST_IRQ_PIN_ROUTE_B       = 8'h00;
	localparam logic [7:0] RST_SHARED_PIN_FUNCTION   = 8'h00;
	localparam logic [7:0] RST_RX_CLOCK_LOOP_CTRL    = 8'h40;
	localparam logic [7:0] RST_RX_WARNING_CLEAR_CTRL = 8'h39;
	localparam logic [7:0] RST_RX_RESERVED_CTRL      = 8'h64;
	localparam logic [7:0] RST_RX_CLOCK_RATE_MODE    = 8'h06;
	localparam logic [7:0] RST_RX_CLOCK_LOOP_STATUS  = 8'h00;

	// -----------------------------------------------------------------
	// writable bits, reserved bits read as zero
	// -----------------------------------------------------------------
	localparam logic [7:0] MSK_IRQ_PIN_ROUTE_B       = 8'hF7;
	localparam logic [7:0] MSK_SHARED_PIN_FUNCTION   = 8'h33;
	localparam logic [7:0] MSK_RX_CLOCK_LOOP_CTRL    = 8'hCF;
	localparam logic [7:0] MSK_RX_CLOCK_RATE_MODE    = 8'h9F;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int POS_PARITY_IN_USE     = 5;
	localparam int POS_FRAME_IN_USE      = 4;
	localparam int POS_LOOP_ENABLE       = 7;
	localparam int POS_DUTY_CORRECTION   = 6;
	localparam int POS_CLEAR_WARNINGS    = 7;
	localparam int POS_LOW_RATE_MODE     = 7;
	localparam int POS_DELAY_LINE_MODE   = 4;
	localparam int POS_STAT_LOCKED       = 7;
	localparam int POS_STAT_WARN         = 6;
	localparam int POS_STAT_START_WARN   = 5;
	localparam int POS_STAT_END_WARN     = 4;
	localparam int POS_STAT_CLOCK_PRES   = 2;
	localparam int POS_STAT_TRACKING     = 0;
	localparam int POS_SRC_LOOP_WARNING  = 5;
	localparam int POS_SRC_LOOP_LOCKED   = 4;

	// phase: 90 degrees plus n steps of 11.25 degrees, in 1/100 degree
	localparam int          PHASE_BASE_CDEG = 9000;
	localparam int          PHASE_STEP_CDEG = 1125;
	localparam logic [2:0]  PHASE_MAG_MAX   = 3'h6;

	// shared pin function codes
	typedef enum logic [1:0] {
		PIN_NO_EFFECT = 2'b00,
		PIN_PARITY    = 2'b01,
		PIN_FRAME     = 2'b10,
		PIN_RESERVED  = 2'b11
	} pin_function_type;

	// status coming from the loop and the clock receiver
	typedef struct packed {
		logic locked;
		logic near_warn;
		logic start_warn;
		logic end_warn;
		logic data_clock_present;
		logic loop_tracking;
	} loop_status_type;

	// controls going out to the loop and the receiver
	typedef struct packed {
		logic       loop_enable;
		logic       duty_correction;
		logic [3:0] phase_step;
		logic       phase_valid;
		logic       parity_select;
		logic       frame_select;
		logic       parity_in_use;
		logic       frame_in_use;
		logic       low_rate_clock_mode;
		logic       delay_line_mode;
	} loop_ctrl_type;

endpackage

// *** test/host_model.sv ***
// host side model: register strobes as a serial port decoder gives them
// assumes a free running clk_i and a bank answering one edge after a read
`timescale 1ns/1ps
`default_nettype none

module host_model
(
	// clock
	input  wire logic       clk_i,
	// register access
	output var  logic       wr_en_o,
	output var  logic       rd_en_o,
	output var  logic [7:0] addr_o,
	output var  logic [7:0] wdata_o,
	input  wire logic [7:0] rdata_i
);
	// idle bus
	initial
	begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o  = 8'hFF;
		wdata_o = 8'h00;
	end

	// one write; stale address and data are inverted afterwards
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_en_o <= 1'b1;
		addr_o  <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_en_o <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask

	// one read, data taken once the strobe edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_en_o <= 1'b1;
		addr_o  <= a;
		@(posedge clk_i);
		rd_en_o <= 1'b0;
		addr_o  <= ~a;
		#1 d = rdata_i;
	endtask

	// shared pin use with the matching usage bit
	task automatic set_pin(input logic [1:0] c);
		wr(8'h09, {2'b00, c == 2'h1, c == 2'h2, 2'b00, c});
	endtask

	// loop or delay line chosen by data clock rate in MHz
	task automatic set_clock_mode(input int mhz);
		logic [7:0] v;
		v = 8'h06;
		if (mhz < 250)
			v[4] = 1'b1;
		else if (mhz < 350)
			v[7] = 1'b1;
		wr(8'h0D, v);
		wr(8'h0B, 8'h39);
		wr(8'h0C, 8'h64);
		wr(8'h0A, {~v[4], 7'h40});
	endtask
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the receive port register bank
// assumes the host model drives the register strobes
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import rx_port_cfg_pkg::*;
();
	logic            clk, rst, ce, wr_en, rd_en, wclr, irq_a_n, irq_b_n;
	logic [7:0]      addr, wdata, rdata, ev, status, r, a, d, e;
	logic [7:0]      sh [16];
	loop_status_type ls;
	loop_ctrl_type   lc;
	int              seed, miscompares, cmp_count;

	rx_port_cfg_regs DUT (.clk_i(clk), .reset_i(rst), .ce_i(ce),
		.wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata),
		.rdata_o(rdata), .event_flag_i(ev), .loop_warn_flag_clr_i(wclr),
		.irq_pin_first_n_o(irq_a_n), .irq_pin_second_n_o(irq_b_n),
		.loop_status_i(ls), .loop_ctrl_o(lc), .status_o(status));

	host_model host (.clk_i(clk), .wr_en_o(wr_en), .rd_en_o(rd_en),
		.addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));

	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		cmp_count++;
		if (got !== want)
		begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	// verdict and end of run
	task automatic finish_test();
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// bits that a write keeps
	function automatic logic [7:0] msk(input logic [7:0] o);
		case (o)
			OFS_IRQ_PIN_ROUTE_B:     return MSK_IRQ_PIN_ROUTE_B;
			OFS_SHARED_PIN_FUNCTION: return MSK_SHARED_PIN_FUNCTION;
			OFS_RX_CLOCK_LOOP_CTRL:  return MSK_RX_CLOCK_LOOP_CTRL;
			OFS_RX_CLOCK_RATE_MODE:  return MSK_RX_CLOCK_RATE_MODE;
			8'h0B, 8'h0C:            return 8'hFF;
			default:                 return 8'h00;
		endcase
	endfunction

	// signed magnitude offset to step and valid flag
	function automatic logic [4:0] phase(input logic [3:0] n);
		logic [3:0] m;
		m = {1'b0, n[2:0]};
		if (m > 4'h6)
			return 5'h00;
		return {n[3] ? -m : m, 1'b1};
	endfunction

	// value after reset by offset, unmapped reads zero
	function automatic logic [7:0] rst_val(input logic [7:0] o);
		case (o)
			OFS_RX_CLOCK_LOOP_CTRL:    return RST_RX_CLOCK_LOOP_CTRL;
			OFS_RX_WARNING_CLEAR_CTRL: return RST_RX_WARNING_CLEAR_CTRL;
			OFS_RX_RESERVED_CTRL:      return RST_RX_RESERVED_CTRL;
			OFS_RX_CLOCK_RATE_MODE:    return RST_RX_CLOCK_RATE_MODE;
			default:                   return 8'h00;
		endcase
	endfunction

	// shadow back to reset values, then read every register
	task automatic chk_reset();
		for (int i = 0; i < 16; i++)
			sh[i] = rst_val(8'(i));
		for (int i = 8; i < 15; i++)
		begin
			host.rd(8'(i), r);
			chk(r, sh[i]);
		end
	endtask

	// wait for registered outputs to settle
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		finish_test();
	end

	// main sequence
	initial
	begin
		seed = 40;
		miscompares = 0;
		cmp_count = 0;
		rst = 1'b1;
		ev = 8'h00;
		wclr = 1'b0;
		ls = '0;
		ce = 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// reset values
		chk_reset();
		// random writes and read back, unmapped and status included
		repeat (40)
		begin
			a = 8'h07 + 8'({$random(seed)} % 9);
			d = 8'($random(seed));
			host.wr(a, d);
			if (a != 8'h0E)
				sh[a[3:0]] = d & msk(a);
			host.rd(a, r);
			chk(r, sh[a[3:0]]);
		end
		// pin routing of each event flag source
		repeat (20)
		begin
			a = 8'($random(seed));
			e = 8'($random(seed));
			host.wr(8'h08, a);
			@(posedge clk);
			ev <= e;
			settle();
			chk({irq_a_n, irq_b_n}, {~|(e & ~a & 8'hD7), ~|(e & a & 8'hD7)});
		end
		ev <= 8'h00;
		// shared pin codes
		for (int c = 0; c < 4; c++)
		begin
			host.set_pin(2'(c));
			settle();
			chk({lc.parity_select, lc.frame_select, lc.parity_in_use,
				lc.frame_in_use}, {c == 1, c == 2, c == 1, c == 2});
		end
		// a write is ignored while the enable is low
		@(posedge clk);
		ce <= 1'b0;
		host.wr(OFS_SHARED_PIN_FUNCTION, 8'h11);
		ce <= 1'b1;
		host.rd(OFS_SHARED_PIN_FUNCTION, r);
		chk(r, 8'h03);
		// all phase codes, loop enable on odd codes, duty correction on even
		for (int i = 0; i < 16; i++)
		begin
			d = {i[0], ~i[0], 2'b00, 4'(i)};
			host.wr(8'h0A, d);
			settle();
			chk({lc.loop_enable, lc.duty_correction, lc.phase_step,
				lc.phase_valid}, {d[7], d[6], phase(d[3:0])});
		end
		// clock rate modes
		for (int i = 0; i < 7; i++)
		begin
			int mhz;
			mhz = 150 + i * 60;
			host.set_clock_mode(mhz);
			settle();
			chk({lc.loop_enable, lc.low_rate_clock_mode, lc.delay_line_mode},
				{mhz >= 250, mhz >= 250 && mhz < 350, mhz < 250});
		end
		// lock, tracking and clock present with loop on then off
		@(posedge clk);
		ls <= 6'b100011;
		settle();
		host.rd(8'h0E, r);
		chk(r, 8'h85);
		chk(status, 8'h85);
		host.wr(8'h0A, 8'h40);
		settle();
		host.rd(8'h0E, r);
		chk(r, 8'h04);
		// each warning sticks until cleared
		host.wr(8'h08, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			ls <= 6'b010000 >> k;
			@(posedge clk);
			ls <= '0;
			settle();
			host.rd(8'h0E, r);
			chk(r, 8'h40 >> k);
			host.wr(8'h0B, 8'hB9);
			host.rd(8'h0E, r);
			chk(r, 8'h00);
		end
		// latched loop warning follows its route until cleared
		chk({irq_a_n, irq_b_n}, 8'h01);
		host.wr(8'h08, 8'h20);
		settle();
		chk({irq_a_n, irq_b_n}, 8'h02);
		@(posedge clk);
		wclr <= 1'b1;
		@(posedge clk);
		wclr <= 1'b0;
		settle();
		chk({irq_a_n, irq_b_n}, 8'h03);
		// reset in mid run brings every register back
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		chk_reset();
		finish_test();
	end
endmodule

`default_nettype wire
